// File: hw/cwg_defines.svh
// Register offsets, field positions, reset values and timing figures of the
// complementary waveform generator.
// Assumes inclusion by bare name from the package and the top module.
`ifndef CWG_DEFINES_SVH
`define CWG_DEFINES_SVH

// ****************************************************************
// Register offsets (byte register index on the plain register port)
// ****************************************************************
`define CWG_OFF_CTRL0 4'h0
`define CWG_OFF_CTRL1 4'h1
`define CWG_OFF_CLKCON 4'h2
`define CWG_OFF_ISEL 4'h3
`define CWG_OFF_DBR 4'h4
`define CWG_OFF_DBF 4'h5
`define CWG_OFF_STEER 4'h6
`define CWG_OFF_OEN 4'h7
`define CWG_OFF_SHUT 4'h8

// ****************************************************************
// Field positions
// ****************************************************************
`define CWG_CTRL0_EN 7
`define CWG_CTRL0_LD 6
`define CWG_SHUT_STATE 7
`define CWG_SHUT_RESTART 6

// ****************************************************************
// Mode codes of the three-bit mode field
// ****************************************************************
`define CWG_MODE_HALF 3'h0
`define CWG_MODE_PUSHPULL 3'h1
`define CWG_MODE_FB_FWD 3'h2
`define CWG_MODE_FB_REV 3'h3
`define CWG_MODE_STEER_ASYNC 3'h4
`define CWG_MODE_STEER_SYNC 3'h5

// ****************************************************************
// Reset values and timing
// ****************************************************************
`define CWG_RST_BYTE 8'h00
`define CWG_RST_NIBBLE 4'h0
`define CWG_RST_DB 6'h00
`define CWG_HFOSC_MHZ 16

`endif

// File: hw/cwg_pkg.sv
// Types shared by the complementary waveform generator.
// Assumes the constants header sits beside it.
`include "cwg_defines.svh"

package cwg_pkg;

  // Register port request, one cycle per strobe
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } cwg_bus_t;

  // Four output pins: level and drive enable, bit 0 is output_a
  typedef struct packed {
    logic [3:0] level;
    logic [3:0] oe;
  } cwg_pins_t;

  // Whole state of the generator
  typedef struct packed {
    logic en;
    logic ld;
    logic [2:0] mode;
    logic [3:0] pol;
    logic cs;
    logic [3:0] isel;
    logic [5:0] dbr_buf;
    logic [5:0] dbf_buf;
    logic [5:0] dbr;
    logic [5:0] dbf;
    logic [3:0] steer;
    logic [3:0] oen;
    logic [3:0] ovr;
    logic restart;
    logic shut;
    logic in_s;
    logic in_p;
    logic osc_p;
    logic [5:0] rcnt;
    logic [5:0] fcnt;
    logic pp_next;
    logic pp_cur;
    logic dir;
    logic fb_pend;
    logic [5:0] fb_cnt;
    logic [3:0] steer_act;
    cwg_pins_t pins;
    logic [7:0] rdata;
  } cwg_state_t;

endpackage

// File: hw/cwg_top.sv
// Complementary waveform generator: one selected modulating input drives
// four outputs in half-bridge, push-pull, full-bridge or steering modes.
// Assumes all inputs synchronous to sys_clk and a register master that
// follows the one-cycle strobe protocol of the plain register port.
//
// Functional notes
// R1: Six modes chosen by control mode field.
// R2: Half-bridge: true and inverted outputs, dead-band.
// R3: Half-bridge: C and D copy, own polarity.
// R4: Push-pull alternates pulses between A and B.
// R5: Sequencer reset when disabled or shut down.
// R6: First pulse after reset goes to A.
// R7: Push-pull: C, D copy A, B.
// R8: Forward: A active, B C inactive, D modulated.
// R9: Reverse: C active, A D inactive, B modulated.
// R10: Dead-band on every full-bridge direction change.
// R11: Direction bit may toggle while running.
// R12: Steering routes input to any output subset.
// R13: Synchronous steering updates at input rising edge.
// R14: Asynchronous steering updates next cycle.
// R15: Clock-select bit picks system or 16 MHz clock.
// R16: Input chosen from sixteen sources.
// R17: Cleared output enable releases the pin.
// R18: Enabled pin shows override or waveform.
// R19: Module disabled: enables and levels ignored.
// R20: Auto-shutdown available in every mode.
// R21: Polarity per output, not on overrides.
// R22: Separate 6-bit rising and falling dead-band counters.
// R23: Unassigned mode codes release all outputs.
`timescale 1ns/1ps
`default_nettype none
`include "cwg_defines.svh"

module cwg_top (
  input wire logic sys_clk,
  input wire logic rst,
  input wire cwg_pkg::cwg_bus_t bus,
  output logic [7:0] reg_rdata,
  input wire logic [15:0] source_in,
  input wire logic hfosc_in,
  input wire logic fault_in,
  output cwg_pkg::cwg_pins_t pins
);
  import cwg_pkg::*;

  // ****************************************************************
  // Decoding helpers
  // ****************************************************************

  // True for the two full-bridge codes, which differ only in bit 0
  function automatic logic is_fb(input logic [2:0] m);
    return (m | 3'h1) == `CWG_MODE_FB_REV; // R11
  endfunction

  // True for the six assigned mode codes
  function automatic logic is_valid(input logic [2:0] m);
    return m <= `CWG_MODE_STEER_SYNC; // R23
  endfunction

  cwg_state_t st_q; // Registered state
  cwg_state_t st_d; // Next state
  logic tick; // One module clock period has passed
  logic rise; // Modulating input rising edge
  logic fall; // Modulating input falling edge
  logic rdone; // Rising dead-band count complete
  logic fdone; // Falling dead-band count complete
  logic [3:0] wave; // Active waveform before polarity
  logic [3:0] level; // Pin level after polarity and override
  logic pp_sel; // Push-pull leg in force this cycle, 1 selects B
  logic [3:0] steer_sel; // Steering selection in force this cycle

  assign reg_rdata = st_q.rdata;
  assign pins = st_q.pins;

  // ****************************************************************
  // Module clock and edge detection
  // ****************************************************************

  // The oscillator is sampled, so it only paces the dead-band counters;
  // its edges must be slower than half of sys_clk to be seen
  assign tick = st_q.cs ? (hfosc_in & ~st_q.osc_p) : 1'b1; // R15
  assign rise = st_q.in_s & ~st_q.in_p;
  assign fall = ~st_q.in_s & st_q.in_p;
  assign rdone = st_q.rcnt == st_q.dbr; // R22
  assign fdone = st_q.fcnt == st_q.dbf; // R22

  // A pulse starts on its new leg; the stored leg would leak one
  // cycle of every pulse after the first onto the wrong output
  assign pp_sel = rise ? st_q.pp_next : st_q.pp_cur; // R4 R6
  // The edge that applies a synchronous selection steers its own pulse
  assign steer_sel = (st_q.mode == `CWG_MODE_STEER_SYNC && rise) ? st_q.steer
                                                                : st_q.steer_act; // R13

  // ****************************************************************
  // Waveform per mode
  // ****************************************************************

  // Raw active waveform of each output, A in bit 0
  always_comb
  begin
    wave = 4'h0;
    unique case (st_q.mode)
      `CWG_MODE_HALF:
      begin
        // True output waits rising dead band, inverted waits falling one
        wave[0] = st_q.in_s & rdone; // R2
        wave[1] = ~st_q.in_s & fdone; // R2
        wave[2] = wave[0]; // R3
        wave[3] = wave[1]; // R3
      end
      `CWG_MODE_PUSHPULL:
      begin
        wave[0] = st_q.in_s & ~pp_sel; // R4
        wave[1] = st_q.in_s & pp_sel; // R4
        wave[2] = wave[0]; // R7
        wave[3] = wave[1]; // R7
      end
      `CWG_MODE_FB_FWD, `CWG_MODE_FB_REV:
      begin
        // Applied direction, not the field, steers the bridge legs
        wave[0] = ~st_q.dir; // R8
        wave[2] = st_q.dir; // R9
        wave[3] = ~st_q.dir & st_q.in_s & ~st_q.fb_pend; // R8 R10
        wave[1] = st_q.dir & st_q.in_s & ~st_q.fb_pend; // R9 R10
      end
      `CWG_MODE_STEER_ASYNC, `CWG_MODE_STEER_SYNC:
      begin
        wave = {4{st_q.in_s}} & steer_sel; // R12 R13
      end
      default:
      begin
        wave = 4'h0; // R23
      end
    endcase
  end

  // Per output: override during shutdown, otherwise polarity applies
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_pin
      // Polarity set means active high; overrides bypass it
      assign level[gi] = st_q.shut ? st_q.ovr[gi]
                                   : (st_q.pol[gi] ? wave[gi] : ~wave[gi]); // R20 R21
    end
  endgenerate

  // ****************************************************************
  // Next-state logic
  // ****************************************************************

  // Register port, sequencers, counters and pins
  always_comb
  begin
    st_d = st_q;

    // Input selection and edge history
    st_d.in_s = source_in[st_q.isel]; // R16
    st_d.in_p = st_q.in_s;
    st_d.osc_p = hfosc_in;

    // Register writes
    if (bus.wr)
    begin
      unique case (bus.addr)
        `CWG_OFF_CTRL0:
        begin
          st_d.en = bus.wdata[`CWG_CTRL0_EN];
          st_d.ld = bus.wdata[`CWG_CTRL0_LD];
          st_d.mode = bus.wdata[2:0]; // R1 R11
        end
        `CWG_OFF_CTRL1: st_d.pol = bus.wdata[3:0]; // R21
        `CWG_OFF_CLKCON: st_d.cs = bus.wdata[0]; // R15
        `CWG_OFF_ISEL: st_d.isel = bus.wdata[3:0]; // R16
        `CWG_OFF_DBR: st_d.dbr_buf = bus.wdata[5:0];
        `CWG_OFF_DBF: st_d.dbf_buf = bus.wdata[5:0];
        `CWG_OFF_STEER: st_d.steer = bus.wdata[3:0]; // R12
        `CWG_OFF_OEN: st_d.oen = bus.wdata[3:0]; // R17
        `CWG_OFF_SHUT:
        begin
          st_d.shut = bus.wdata[`CWG_SHUT_STATE];
          st_d.restart = bus.wdata[`CWG_SHUT_RESTART];
          st_d.ovr = bus.wdata[3:0];
        end
        default:
        begin
          // Unmapped writes are dropped
        end
      endcase
    end

    // Dead-band buffers: immediate while disabled, else on load request
    if (!st_q.en)
    begin
      st_d.dbr = st_d.dbr_buf;
      st_d.dbf = st_d.dbf_buf;
    end
    else if (st_q.ld && fall)
    begin
      st_d.dbr = st_q.dbr_buf;
      st_d.dbf = st_q.dbf_buf;
      st_d.ld = 1'b0;
    end

    // Rising counter runs while input high, falling counter while low;
    // an input pulse shorter than the count yields no output pulse
    if (!st_q.in_s)
      st_d.rcnt = 6'h00;
    else if (tick && !rdone)
      st_d.rcnt = 6'(st_q.rcnt + 6'h01); // R22
    if (st_q.in_s)
      st_d.fcnt = 6'h00;
    else if (tick && !fdone)
      st_d.fcnt = 6'(st_q.fcnt + 6'h01); // R22

    // Push-pull sequencer, steps on each rising edge
    if (rise)
    begin
      st_d.pp_cur = st_q.pp_next; // R6
      st_d.pp_next = ~st_q.pp_next; // R4
    end

    // Full-bridge direction applies at the first rising edge after change
    if (is_fb(st_q.mode) && rise && (st_q.mode[0] != st_q.dir))
    begin
      st_d.dir = st_q.mode[0]; // R11
      st_d.fb_pend = 1'b1; // R10
      st_d.fb_cnt = 6'h00;
    end
    else if (st_q.fb_pend && tick)
    begin
      // Reverse uses the rising count, forward the falling count
      if (st_q.fb_cnt == (st_q.dir ? st_q.dbr : st_q.dbf))
        st_d.fb_pend = 1'b0; // R10
      else
        st_d.fb_cnt = 6'(st_q.fb_cnt + 6'h01);
    end

    // Steering selection takes effect per mode
    if (st_q.mode == `CWG_MODE_STEER_ASYNC)
      st_d.steer_act = st_q.steer; // R14
    else if (st_q.mode == `CWG_MODE_STEER_SYNC && rise)
      st_d.steer_act = st_q.steer; // R13

    // Shutdown: fault sets, auto-restart clears once fault is gone;
    // the fault wins over any software clear in the same cycle
    if (st_q.restart && !fault_in)
      st_d.shut = 1'b0;
    if (fault_in)
      st_d.shut = 1'b1; // R20

    // Sequencer held at start while disabled or shut down
    if (!st_q.en || st_q.shut || fault_in)
    begin
      st_d.pp_next = 1'b0; // R5
      st_d.pp_cur = 1'b0; // R5
    end

    // Pins: released unless module, pin and mode all enabled
    st_d.pins.level = level; // R18
    st_d.pins.oe = (st_q.en && is_valid(st_q.mode)) ? st_q.oen : 4'h0; // R17 R19 R23

    // Register reads answer in the next cycle
    st_d.rdata = `CWG_RST_BYTE;
    if (bus.rd)
    begin
      unique case (bus.addr)
        `CWG_OFF_CTRL0: st_d.rdata = {st_q.en, st_q.ld, 3'h0, st_q.mode};
        `CWG_OFF_CTRL1: st_d.rdata = {st_q.pins.level, st_q.pol};
        `CWG_OFF_CLKCON: st_d.rdata = {7'h00, st_q.cs};
        `CWG_OFF_ISEL: st_d.rdata = {4'h0, st_q.isel};
        `CWG_OFF_DBR: st_d.rdata = {2'h0, st_q.dbr_buf};
        `CWG_OFF_DBF: st_d.rdata = {2'h0, st_q.dbf_buf};
        `CWG_OFF_STEER: st_d.rdata = {st_q.steer_act, st_q.steer};
        `CWG_OFF_OEN: st_d.rdata = {4'h0, st_q.oen};
        `CWG_OFF_SHUT: st_d.rdata = {st_q.shut, st_q.restart, 2'h0, st_q.ovr};
        default: st_d.rdata = `CWG_RST_BYTE;
      endcase
    end
  end

  // ****************************************************************
  // State register
  // ****************************************************************

  // Synchronous reset to all zero: disabled, half-bridge, pins released
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      st_q <= '0;
    else
      st_q <= st_d;
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  AST_BAD_MODE_RELEASE: // R23
    assert property (!is_valid(st_q.mode) |=> pins.oe == 4'h0)
    else $error("Unassigned mode still drives a pin");

  AST_DISABLED_RELEASE: // R19
    assert property (!st_q.en |=> pins.oe == 4'h0)
    else $error("Disabled module drives a pin");

  AST_PIN_ENABLE: // R17
    assert property (st_q.en && is_valid(st_q.mode) |=> pins.oe == $past(st_q.oen))
    else $error("Pin enables do not follow enable bits");

  AST_PP_RESET: // R5
    assert property (!st_q.en |=> !st_q.pp_next && !st_q.pp_cur)
    else $error("Push-pull sequencer not reset");

  AST_PP_ALTERNATE: // R4
    assert property (st_q.en && !st_q.shut && !fault_in && rise
                     |=> st_q.pp_next != $past(st_q.pp_next))
    else $error("Push-pull sequencer did not step");

  AST_FB_FORWARD: // R8
    assert property (is_fb(st_q.mode) && !st_q.dir && !st_q.shut
                     |=> pins.level[0] == $past(st_q.pol[0])
                         && pins.level[2] == ~$past(st_q.pol[2]))
    else $error("Forward bridge legs wrong");

  AST_FB_DEADBAND: // R10
    assert property (is_fb(st_q.mode) && st_q.fb_pend && !st_q.shut
                     |=> pins.level[1] == ~$past(st_q.pol[1])
                         && pins.level[3] == ~$past(st_q.pol[3]))
    else $error("Bridge modulated during dead band");

  AST_HB_DEADBAND: // R22
    assert property (st_q.mode == `CWG_MODE_HALF && !st_q.shut && !rdone
                     |=> pins.level[0] == ~$past(st_q.pol[0]))
    else $error("Half-bridge output rose inside dead band");

  AST_SHUT_OVERRIDE: // R20
    assert property (st_q.shut |=> pins.level == $past(st_q.ovr))
    else $error("Shutdown override not applied");

  AST_ASYNC_STEER: // R14
    assert property (st_q.mode == `CWG_MODE_STEER_ASYNC ##1
                     st_q.mode == `CWG_MODE_STEER_ASYNC |-> st_q.steer_act == $past(st_q.steer))
    else $error("Asynchronous steering lagged");

  AST_SYNC_STEER: // R13
    assert property (st_q.mode == `CWG_MODE_STEER_SYNC && !rise |=> $stable(st_q.steer_act))
    else $error("Synchronous steering changed without an edge");

  // Second pulse of a pair must not leak a cycle onto leg A
  AST_PP_NO_LEAK_A: // R4
    assert property (st_q.mode == `CWG_MODE_PUSHPULL && !st_q.shut && rise && st_q.pp_next
                     |=> pins.level[0] == ~$past(st_q.pol[0]))
    else $error("Push-pull pulse leaked onto output A");

  // First pulse of a pair must not leak a cycle onto leg B
  AST_PP_NO_LEAK_B: // R6
    assert property (st_q.mode == `CWG_MODE_PUSHPULL && !st_q.shut && rise && !st_q.pp_next
                     |=> pins.level[1] == ~$past(st_q.pol[1]))
    else $error("Push-pull pulse leaked onto output B");

  // The edge that applies a new selection already steers its pulse
  AST_SYNC_STEER_EDGE: // R13
    assert property (st_q.mode == `CWG_MODE_STEER_SYNC && !st_q.shut && rise
                     |=> pins.level == ($past(st_q.pol) ~^ $past(st_q.steer)))
    else $error("Synchronous steering missed its applying edge");

endmodule // cwg_top

`default_nettype wire

// File: tb/cwg_bridge_model.sv
// Power bridge stand-in: four gate drivers with pull-downs behind the pins.
// Assumes pins come straight from the generator, A and B on one leg.
`timescale 1ns/1ps
`default_nettype none

module cwg_bridge_model (
  input wire logic sys_clk,
  input wire cwg_pkg::cwg_pins_t pins,
  output logic [3:0] pad,
  output var int shoot_cnt
);
  import cwg_pkg::*;

  // **********
  // Pin levels
  // **********
  // A released pin falls to the pull-down level, never keeps its last value
  assign pad = pins.oe & pins.level;

  // Both switches of leg one on together would short the supply
  always @(posedge sys_clk)
  begin
    if (pad[0] && pad[1])
      shoot_cnt <= shoot_cnt + 1;
  end

endmodule // cwg_bridge_model
`default_nettype wire

// File: tb/tb_complementary_waveform_generator.sv
// Self-checking bench of the waveform generator: register tasks and mode walks.
// Assumes the hw files and the bridge model; source 3 is the selected input.
`timescale 1ns/1ps
`default_nettype none
`include "cwg_defines.svh"

module tb_complementary_waveform_generator;
  import cwg_pkg::*;
  logic sys_clk = 1'b0; // 200 MHz
  logic rst = 1'b1;
  cwg_bus_t bus = '0;
  logic [7:0] reg_rdata;
  logic [15:0] source_in = 16'hfff7; // Unselected sources oppose the chosen one
  logic hfosc_in = 1'b0;
  logic fault_in = 1'b0;
  cwg_pins_t pins;
  logic [3:0] pad;
  int shoot_cnt;
  int fail_count = 0;
  int num_checks = 0;
  int osc_div = 0;
  int n;

  always #2.5 sys_clk = ~sys_clk;

  // Oscillator stand-in with a 12-cycle period, slower than half sys_clk
  always @(posedge sys_clk)
  begin
    osc_div <= (osc_div == 5) ? 0 : osc_div + 1;
    if (osc_div == 5)
      hfosc_in <= ~hfosc_in;
  end

  cwg_top DUT (.sys_clk(sys_clk), .rst(rst), .bus(bus), .reg_rdata(reg_rdata),
    .source_in(source_in), .hfosc_in(hfosc_in), .fault_in(fault_in), .pins(pins));
  cwg_bridge_model BRIDGE (.sys_clk(sys_clk), .pins(pins), .pad(pad), .shoot_cnt(shoot_cnt));

  // **********
  // Tasks
  // **********
  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic idle(input int c);
    repeat (c) @(posedge sys_clk);
    #1;
  endtask

  // One-cycle write strobe, then an idle edge
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge sys_clk);
    bus <= '0;
  endtask

  // Read data stand only in the cycle after the taking edge
  task automatic rdc(input string name, input logic [3:0] a, input logic [7:0] exp);
    @(posedge sys_clk);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge sys_clk);
    bus <= '0;
    #1;
    chk(name, reg_rdata, exp);
  endtask

  task automatic src(input logic v);
    @(posedge sys_clk);
    source_in <= v ? 16'h0008 : 16'hfff7;
  endtask

  task automatic pc(input string name, input logic [3:0] exp);
    chk(name, {4'h0, pad}, {4'h0, exp});
  endtask

  // Disable first so the sequencer and dead-band buffers start clean
  task automatic cfg(input logic [2:0] m);
    wr(`CWG_OFF_CTRL0, {5'h00, m});
    wr(`CWG_OFF_CTRL0, {5'h10, m});
    idle(4);
  endtask

  // Cycles from a source edge until the pin reaches level 1
  task automatic lag(input int b, input logic v);
    src(v);
    n = 0;
    while (pad[b] !== 1'b1 && n < 200)
    begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    #1;
  endtask

  function automatic logic [7:0] win(input int cnt, input int db, input int cs);
    int u;
    u = cs ? 12 : 1;
    return {7'h00, cnt >= (db - 1) * u + 1 && cnt <= db * u + 3};
  endfunction

  task automatic complete_run;
    if (fail_count == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // **********
  // Tests
  // **********
  initial
  begin
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    rdc("ctrl0", `CWG_OFF_CTRL0, 8'h00);
    wr(`CWG_OFF_OEN, 8'h0f);
    wr(`CWG_OFF_CTRL1, 8'h0f);
    wr(`CWG_OFF_ISEL, 8'h03);
    wr(4'hf, 8'hff);
    rdc("unmapped", 4'hf, 8'h00);
    rdc("clksel", `CWG_OFF_CLKCON, 8'h00);
    idle(3);
    chk("oe_off", {4'h0, pins.oe}, 8'h00);
    cfg(`CWG_MODE_HALF);
    chk("oe_on", {4'h0, pins.oe}, 8'h0f);
    src(1'b1);
    idle(4);
    pc("half_hi", 4'b0101);
    src(1'b0);
    idle(4);
    pc("half_lo", 4'b1010);
    // Dead band from the system clock, then from the oscillator
    for (int cs = 0; cs < 2; cs++)
    begin
      wr(`CWG_OFF_CTRL0, 8'h00);
      wr(`CWG_OFF_CLKCON, 8'(cs));
      wr(`CWG_OFF_DBR, 8'h03);
      wr(`CWG_OFF_DBF, 8'h02);
      wr(`CWG_OFF_CTRL0, 8'h80);
      idle(6);
      lag(0, 1'b1);
      chk("rise_lag", win(n, 3, cs), 8'h01);
      idle(8);
      lag(1, 1'b0);
      chk("fall_lag", win(n, 2, cs), 8'h01);
    end
    chk("shoot", 8'(shoot_cnt), 8'h00);
    wr(`CWG_OFF_CTRL0, 8'h00);
    wr(`CWG_OFF_CLKCON, 8'h00);
    wr(`CWG_OFF_DBF, 8'h00);
    wr(`CWG_OFF_DBR, 8'h00);
    // Alternation, then restart from A after a disable
    cfg(`CWG_MODE_PUSHPULL);
    for (int k = 0; k < 3; k++)
    begin
      if (k == 2)
        cfg(`CWG_MODE_PUSHPULL);
      src(1'b1);
      idle(4);
      pc("pushpull", (k == 1) ? 4'b1010 : 4'b0101);
      src(1'b0);
      idle(4);
    end
    wr(`CWG_OFF_CTRL0, 8'h00);
    wr(`CWG_OFF_DBR, 8'h04);
    cfg(`CWG_MODE_FB_FWD);
    pc("fwd_lo", 4'b0001);
    src(1'b1);
    idle(4);
    pc("fwd_hi", 4'b1001);
    src(1'b0);
    wr(`CWG_OFF_CTRL0, 8'h83);
    idle(4);
    pc("dir_wait", 4'b0001);
    src(1'b1);
    idle(3);
    pc("rev_gap", 4'b0100);
    idle(6);
    pc("rev_hi", 4'b0110);
    src(1'b0);
    idle(4);
    pc("rev_lo", 4'b0100);
    cfg(`CWG_MODE_STEER_ASYNC);
    wr(`CWG_OFF_STEER, 8'h05);
    src(1'b1);
    idle(4);
    pc("steer", 4'b0101);
    wr(`CWG_OFF_STEER, 8'h0f);
    idle(3);
    pc("steer_all", 4'b1111);
    wr(`CWG_OFF_CTRL0, 8'h85);
    wr(`CWG_OFF_STEER, 8'h0a);
    idle(4);
    pc("sync_hold", 4'b1111);
    src(1'b0);
    idle(2);
    src(1'b1);
    idle(4);
    pc("sync_new", 4'b1010);
    wr(`CWG_OFF_OEN, 8'h03);
    idle(3);
    chk("oe_sub", {4'h0, pins.oe}, 8'h03);
    pc("released", 4'b0010);
    wr(`CWG_OFF_CTRL0, 8'h86);
    idle(3);
    chk("oe_badmode", {4'h0, pins.oe}, 8'h00);
    wr(`CWG_OFF_OEN, 8'h0f);
    wr(`CWG_OFF_CTRL1, 8'h00);
    wr(`CWG_OFF_SHUT, 8'h06);
    cfg(`CWG_MODE_HALF);
    @(posedge sys_clk);
    fault_in <= 1'b1;
    idle(4);
    pc("override", 4'b0110);
    rdc("shut_state", `CWG_OFF_SHUT, 8'h86);
    @(posedge sys_clk);
    fault_in <= 1'b0;
    wr(`CWG_OFF_SHUT, 8'h06);
    idle(4);
    pc("active_low", 4'b1010);
    complete_run();
  end

  // Watchdog: the walk needs well under 3000 cycles
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    fail_count++;
    complete_run();
  end
endmodule // tb_complementary_waveform_generator
`default_nettype wire
